// ---- hdl/i2c_dsr_map.svh ----
`ifndef I2C_DSR_MAP_SVH
`define I2C_DSR_MAP_SVH

// register byte offsets on the apb side
`define OFS_CTRL 8'h00
`define OFS_OWN_ADDR 8'h08
`define OFS_DATA 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18

// reset values
`define RST_CTRL 16'h0000
`define RST_OWN_ADDR 16'h0000
`define RST_STATUS 16'h0000
`define RST_MASK 16'h0000

// control register fields
`define CTRL_PE_BIT 0
`define CTRL_ACK_BIT 1
`define CTRL_STRETCH_DIS_BIT 2
`define CTRL_PEC_BIT 3
`define CTRL_USED 16'h000f

// status register one fields
`define ST_CHECK_ERR_BIT 12
`define ST_OVERRUN_BIT 11
`define ST_ACK_FAIL_BIT 10
`define ST_ARB_LOST_BIT 9
`define ST_BUS_ERR_BIT 8
`define ST_TX_EMPTY_BIT 7
`define ST_RX_NOT_EMPTY_BIT 6
`define ST_STOP_SEEN_BIT 4
`define ST_BYTE_FIN_BIT 2
`define ST_ADDR_MATCH_BIT 1
`define ST_START_SENT_BIT 0
`define ST_USED 16'h1fd7

// own address and data field layout
`define OWN_ADDR_USED 16'h00fe
`define DATA_USED 16'h00ff

// bit counts on the link and the check polynomial
`define BITS_PER_BYTE 4'h8
`define ACK_DONE_CNT 4'h9
`define CHECK_POLY 8'h07

`endif

// ---- hdl/i2c_dsr_pkg.sv ----
package i2c_dsr_pkg;
  // slave side link sequencing
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_rx,
    st_tx,
    st_wait
  } link_state_e;
endpackage

// ---- hdl/i2c_bit_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for one pin level
module i2c_bit_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and synchronised level out
  input wire logic din,
  output logic dout
);
  logic meta_q; // first stage, read only by the second stage
  // idle bus level is high, so both stages reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // i2c_bit_sync
`default_nettype wire

// ---- hdl/i2c_data_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_dsr_map.svh"
module i2c_data_status_regs
  import i2c_dsr_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // i2c data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // arbitration loss pulse from the master core
  input wire logic arb_lost_in,
  // interrupt
  output logic irq
);
  // register state
  logic [15:0] ctrl_q; // enable, ack, stretch disable, check byte next
  logic [6:0] own_addr_q; // own slave address
  logic [7:0] tx_buf_q; // transmit_buffer
  logic [7:0] rx_buf_q; // receive_buffer
  logic [15:0] mask_q; // interrupt mask, status layout
  logic txe_q, receive_not_empty_flag_q, check_error_flag_q, ovr_q, af_q, arbitration_lost_flag_q, bus_error_flag_q, stop_seen_flag_q, btf_q, addrf_q;
  // link state
  link_state_e state_q;
  logic [3:0] bit_cnt_q; // scl rises seen in this byte
  logic [7:0] shift_q; // receive shifter
  logic [7:0] tx_shift_q; // transmit shifter
  logic [7:0] crc_q; // running check value
  logic mack_q; // master acked our byte
  logic discard_q; // arbitration lost during the ack slot
  logic stretch_q; // holding scl low
  logic scl_s, sda_s, scl_p_q, sda_p_q;

  // pins pass two flops before any logic reads them
  i2c_bit_sync u_scl_sync (.clk(pclk), .rst_n(presetn), .din(scl_i), .dout(scl_s));
  i2c_bit_sync u_sda_sync (.clk(pclk), .rst_n(presetn), .din(sda_i), .dout(sda_s));

  // previous synchronised levels for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // control bits
  wire pe = ctrl_q[`CTRL_PE_BIT];
  wire ack_en = ctrl_q[`CTRL_ACK_BIT];
  wire no_stretch = ctrl_q[`CTRL_STRETCH_DIS_BIT];
  wire pec_next = ctrl_q[`CTRL_PEC_BIT];

  // bus events
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_ev = pe & scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev = pe & scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire busy = (state_q == st_addr) | (state_q == st_rx) | (state_q == st_tx);
  wire ack_fall = pe & busy & scl_fall & (bit_cnt_q == `BITS_PER_BYTE);
  wire end_fall = pe & busy & scl_fall & (bit_cnt_q == `ACK_DONE_CNT) & ~stretch_q;
  wire mid_byte = busy & (bit_cnt_q != 4'h0) & (bit_cnt_q != `ACK_DONE_CNT);
  wire addr_hit = shift_q[7:1] == own_addr_q;
  wire addr_ack = ack_fall & (state_q == st_addr) & addr_hit & ack_en;
  wire pec_bad = ack_fall & (state_q == st_rx) & pec_next & (shift_q != crc_q);
  wire rx_ack = pec_next ? ((shift_q == crc_q) & ack_en) : ack_en;
  wire rx_end = end_fall & (state_q == st_rx);
  wire rx_commit = rx_end & ~discard_q & ~receive_not_empty_flag_q;
  wire rx_over = rx_end & ~discard_q & receive_not_empty_flag_q & no_stretch;
  wire addr_end = end_fall & (state_q == st_addr);
  wire tx_end = end_fall & (state_q == st_tx);
  wire tx_start = (addr_end & shift_q[0]) | (tx_end & mack_q);
  wire tx_under = tx_end & mack_q & txe_q & no_stretch;
  wire stretch_go = ack_fall & (state_q == st_rx) & receive_not_empty_flag_q & ~no_stretch;

  // apb decode
  wire acc_setup = psel & penable & ~pready;
  wire acc_done = psel & penable & pready;
  wire wr_done = acc_done & pwrite;
  wire rd_done = acc_done & ~pwrite;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire hit_oar = paddr == `OFS_OWN_ADDR;
  wire hit_data = paddr == `OFS_DATA;
  wire hit_stat = paddr == `OFS_STATUS;
  wire hit_mask = paddr == `OFS_MASK;
  wire mapped = hit_ctrl | hit_oar | hit_data | hit_stat | hit_mask;
  wire dr_wr = wr_done & hit_data;
  wire dr_rd = rd_done & hit_data;
  wire st_wr = wr_done & hit_stat;

  // status word; reserved bits stay zero, start-sent is master only
  wire [15:0] status_w = {3'h0, check_error_flag_q, ovr_q, af_q, arbitration_lost_flag_q, bus_error_flag_q, txe_q, receive_not_empty_flag_q,
                          1'b0, stop_seen_flag_q, 1'b0, btf_q, addrf_q, 1'b0};
  logic [15:0] rd_mux;

  // read data selection
  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      hit_ctrl: rd_mux = ctrl_q & `CTRL_USED;
      hit_oar: rd_mux = {8'h00, own_addr_q, 1'b0} & `OWN_ADDR_USED;
      hit_data: rd_mux = {8'h00, rx_buf_q};
      hit_stat: rd_mux = status_w;
      hit_mask: rd_mux = mask_q & `ST_USED;
      default: rd_mux = 16'h0000;
    endcase
  end

  // one wait state so read data and ready leave flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_setup;
      pslverr <= acc_setup & ~mapped;
      if (acc_setup) begin
        prdata <= {16'h0000, rd_mux};
      end
    end
  end

  // control register; software set of the check bit beats hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RST_CTRL;
    end else if (wr_done & hit_ctrl) begin
      ctrl_q <= pwdata[15:0] & `CTRL_USED;
    end else if (rx_end) begin
      ctrl_q[`CTRL_PEC_BIT] <= 1'b0;
    end
  end

  // own address and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_q <= 7'(`RST_OWN_ADDR >> 1);
      mask_q <= `RST_MASK;
    end else begin
      if (wr_done & hit_oar) begin
        own_addr_q <= pwdata[7:1];
      end
      if (wr_done & hit_mask) begin
        mask_q <= pwdata[15:0] & `ST_USED;
      end
    end
  end

  // transmit buffer: writes always land, even over a pending byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q <= 8'h00;
    end else if (dr_wr) begin
      tx_buf_q <= pwdata[7:0];
    end
  end

  // transmit empty: empties as a byte starts out, a write fills it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_q <= 1'b0;
    end else if (!pe | start_ev | stop_ev) begin
      txe_q <= 1'b0;
    end else if (tx_start) begin
      txe_q <= 1'b1;
    end else if (dr_wr) begin
      txe_q <= 1'b0;
    end
  end

  // receive buffer: address bytes and discarded or overrun bytes never land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 8'h00;
    end else if (rx_commit) begin
      rx_buf_q <= shift_q;
    end
  end

  // receive not empty: a new byte wins over a same cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_not_empty_flag_q <= 1'b0;
    end else if (!pe) begin
      receive_not_empty_flag_q <= 1'b0;
    end else if (rx_commit) begin
      receive_not_empty_flag_q <= 1'b1;
    end else if (dr_rd | dr_wr) begin
      receive_not_empty_flag_q <= 1'b0;
    end
  end

  // zero-write clearable error flags; hardware set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_error_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      af_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      bus_error_flag_q <= 1'b0;
    end else if (!pe) begin
      check_error_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      af_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      bus_error_flag_q <= 1'b0;
    end else begin
      check_error_flag_q <= pec_bad | (check_error_flag_q & ~(st_wr & ~pwdata[`ST_CHECK_ERR_BIT]));
      ovr_q <= rx_over | tx_under | (ovr_q & ~(st_wr & ~pwdata[`ST_OVERRUN_BIT]));
      af_q <= (tx_end & ~mack_q) | (af_q & ~(st_wr & ~pwdata[`ST_ACK_FAIL_BIT]));
      arbitration_lost_flag_q <= arb_lost_in | (arbitration_lost_flag_q & ~(st_wr & ~pwdata[`ST_ARB_LOST_BIT]));
      bus_error_flag_q <= ((start_ev | stop_ev) & mid_byte) | (bus_error_flag_q & ~(st_wr & ~pwdata[`ST_BUS_ERR_BIT]));
    end
  end

  // read-only flags: stop seen, byte finished (stretching), address matched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_seen_flag_q <= 1'b0;
      btf_q <= 1'b0;
      addrf_q <= 1'b0;
    end else if (!pe) begin
      stop_seen_flag_q <= 1'b0;
      btf_q <= 1'b0;
      addrf_q <= 1'b0;
    end else begin
      stop_seen_flag_q <= (stop_ev & addrf_q) | (stop_seen_flag_q & ~(wr_done & hit_ctrl));
      btf_q <= stretch_go | (btf_q & stretch_q & receive_not_empty_flag_q);
      addrf_q <= addr_ack | (addrf_q & ~stop_ev);
    end
  end

  // running check value over address and data bytes
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction

  // check value restarts on each start and after a check byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= 8'h00;
    end else if (start_ev | (rx_end & pec_next)) begin
      crc_q <= 8'h00;
    end else if ((addr_end & addrf_q) | rx_end) begin
      crc_q <= crc_step(crc_q, shift_q);
    end
  end

  // arbitration loss inside the ack slot marks the byte for discard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_q <= 1'b0;
    end else if (start_ev | end_fall) begin
      discard_q <= 1'b0;
    end else if (arb_lost_in & (state_q == st_rx) & (bit_cnt_q >= `BITS_PER_BYTE)) begin
      discard_q <= 1'b1;
    end
  end

  // clock stretching: hold scl low until software frees the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_q <= 1'b0;
      scl_oe_n <= 1'b1;
      scl_o <= 1'b0;
    end else if (!pe | (stretch_q & ~receive_not_empty_flag_q)) begin
      stretch_q <= 1'b0;
      scl_oe_n <= 1'b1;
    end else if (stretch_go) begin
      stretch_q <= 1'b1;
      scl_oe_n <= 1'b0;
    end
  end

  // link sequencer: address, receive and transmit bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_shift_q <= 8'h00;
      mack_q <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else if (!pe | stop_ev) begin
      state_q <= st_idle;
      bit_cnt_q <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (start_ev) begin
      state_q <= st_addr;
      bit_cnt_q <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (scl_rise & busy) begin
      // sample data bits; the ninth rise is the ack slot
      if (bit_cnt_q < `BITS_PER_BYTE) begin
        shift_q <= {shift_q[6:0], sda_s};
      end
      if (bit_cnt_q == `BITS_PER_BYTE) begin
        mack_q <= ~sda_s;
      end
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (ack_fall) begin
      // drive the ack slot; a bad check byte is always refused
      unique case (state_q)
        st_addr: sda_oe_n <= ~addr_ack;
        st_rx: sda_oe_n <= ~rx_ack;
        default: sda_oe_n <= 1'b1;
      endcase
    end else if (end_fall) begin
      bit_cnt_q <= 4'h0;
      sda_oe_n <= 1'b1;
      if (state_q == st_addr) begin
        state_q <= addrf_q ? (shift_q[0] ? st_tx : st_rx) : st_wait;
      end else if ((state_q == st_tx) & ~mack_q) begin
        state_q <= st_wait;
      end
      if (tx_start) begin
        // an unwritten buffer resends the same byte
        tx_shift_q <= {tx_buf_q[6:0], 1'b0};
        sda_oe_n <= tx_buf_q[7];
      end
    end else if (scl_fall & (state_q == st_tx) & (bit_cnt_q != 4'h0)) begin
      // later data bits leave msb first on each fall
      sda_oe_n <= tx_shift_q[7];
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
  end

  // level interrupt from unmasked status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_w & mask_q);
    end
  end

  // checks kept next to the logic
  AST_OAR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done & hit_oar |=> own_addr_q == $past(pwdata[7:1]))
    else $error("own address not stored");
  AST_OAR_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    acc_setup & hit_oar |=> prdata[0] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("own address reserved bits not zero");
  AST_DR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    dr_wr & pe & ~tx_start & ~start_ev & ~stop_ev |=> tx_buf_q == $past(pwdata[7:0]) && !txe_q)
    else $error("data write lost");
  AST_TX_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
    tx_start |=> txe_q && sda_oe_n == $past(tx_buf_q[7]))
    else $error("next byte not started");
  AST_RX_COMMIT: assert property (@(posedge pclk) disable iff (!presetn)
    rx_commit |=> receive_not_empty_flag_q && rx_buf_q == $past(shift_q))
    else $error("received byte not copied");
  AST_ADDR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    addr_end |=> $stable(rx_buf_q))
    else $error("address byte entered buffer");
  AST_ARB_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
    rx_end & discard_q |=> $stable(rx_buf_q) && receive_not_empty_flag_q == $past(receive_not_empty_flag_q))
    else $error("discarded byte became readable");
  AST_CHECK_BAD: assert property (@(posedge pclk) disable iff (!presetn)
    pec_bad & ~start_ev & ~stop_ev |=> check_error_flag_q && sda_oe_n)
    else $error("bad check byte not refused");
  AST_CHECK_GOOD: assert property (@(posedge pclk) disable iff (!presetn)
    ack_fall & (state_q == st_rx) & pec_next & ~pec_bad & ~check_error_flag_q & ~st_wr
    |=> !check_error_flag_q && sda_oe_n == !$past(ack_en))
    else $error("good check byte answered wrongly");
  AST_CHECK_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !pe |=> !check_error_flag_q)
    else $error("check error survives disable");
  AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    rx_over & pe |=> ovr_q && rx_buf_q == $past(rx_buf_q) && receive_not_empty_flag_q)
    else $error("overrun not flagged or buffer changed");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(|(status_w & mask_q)))
    else $error("interrupt does not follow status");
endmodule // i2c_data_status_regs
`default_nettype wire

// ---- bench/i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far side bus master: 80 ns bit period, open-drain releases only
module i2c_master_model (
  // levels seen on the bus wires
  input wire logic scl_line,
  input wire logic sda_line,
  // 1 releases the line to its pull-up
  output logic scl_rel,
  output logic sda_rel,
  // count of stretches that never ended
  output logic [7:0] stuck
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    stuck = 8'h00;
  end
  // release scl, then wait (bounded) while a slave holds it low
  task automatic scl_up();
    int n;
    scl_rel = 1'b1;
    n = 0;
    while (scl_line !== 1'b1 && n < 2000) begin
      #10;
      n++;
    end
    if (n >= 2000) stuck = stuck + 8'h01;
  endtask
  // one bit: data set mid low phase, sampled mid high phase
  task automatic bit_cyc(input logic b, output logic s);
    #20 sda_rel = b;
    #20 scl_up();
    #20 s = sda_line;
    #20 scl_rel = 1'b0;
  endtask
  // start or repeated start
  task automatic start_cond();
    #20 sda_rel = 1'b1;
    scl_up();
    #40 sda_rel = 1'b0;
    #40 scl_rel = 1'b0;
  endtask
  // stop: sda rises while scl is high
  task automatic stop_cond();
    #20 sda_rel = 1'b0;
    #20 scl_up();
    #40 sda_rel = 1'b1;
    #40;
  endtask
  // byte out msb first, then the slave's acknowledge (0 = ack)
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
    bit_cyc(1'b1, ack);
    // a long low phase lets the slave's synchronised flags settle
    #60;
  endtask
  // byte in msb first, then our acknowledge bit
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, b[i]);
    end
    bit_cyc(ack, s);
    #60;
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ---- bench/i2c_data_status_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_dsr_map.svh"
// apb-driven checks of own address, data and status one
module i2c_data_status_regs_bench import i2c_dsr_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic arb_lost_in = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic scl_rel, sda_rel;
  logic [7:0] stuck;
  wire logic scl_w;
  wire logic sda_w;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err, ack;
  logic [7:0] b;
  // open-drain wires: pull-up unless either party pulls low
  assign scl_w = scl_rel & (scl_oe_n | scl_o);
  assign sda_w = sda_rel & (sda_oe_n | sda_o);
  always #5 pclk = ~pclk;
  i2c_data_status_regs i2c_data_status_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .arb_lost_in(arb_lost_in), .irq(irq));
  i2c_master_model i2c_master_model_inst (.scl_line(scl_w), .sda_line(sda_w), .scl_rel(scl_rel),
    .sda_rel(sda_rel), .stuck(stuck));
  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("BAD %0t no pready", $time);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // masked register read compare
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd[15:0] & m, exp);
  endtask
  // crc8, poly 0x07, one byte step
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `CHECK_POLY) : (r << 1);
    end
    return r;
  endfunction
  // hang guard
  initial begin
    #800000;
    mismatches++;
    $display("BAD %0t run too long", $time);
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(`OFS_OWN_ADDR, 16'hffff, `RST_OWN_ADDR);
    rc(`OFS_DATA, 16'hffff, 16'h0000);
    rc(`OFS_STATUS, 16'hffff, `RST_STATUS);
    rc(8'h1c, 16'hffff, 16'h0000);
    chk({15'h0, err}, 16'h0001);
    apb(1'b1, `OFS_OWN_ADDR, 16'hffff);
    rc(`OFS_OWN_ADDR, 16'hffff, 16'h00fe);
    apb(1'b1, `OFS_OWN_ADDR, 16'h00b4);
    apb(1'b1, `OFS_STATUS, 16'hffff);
    rc(`OFS_STATUS, 16'hffff, 16'h0000);
    apb(1'b1, `OFS_MASK, 16'h1800);
    apb(1'b1, `OFS_CTRL, 16'h0007);
    // write transfer: address then one byte, then two unread bytes
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'hb4, ack);
    chk({15'h0, ack}, 16'h0000);
    rc(`OFS_STATUS, 16'h0040, 16'h0000);
    i2c_master_model_inst.send_byte(8'hc3, ack);
    rc(`OFS_STATUS, 16'h0040, 16'h0040);
    rc(`OFS_DATA, 16'hffff, 16'h00c3);
    rc(`OFS_STATUS, 16'h0040, 16'h0000);
    i2c_master_model_inst.send_byte(8'h11, ack);
    i2c_master_model_inst.send_byte(8'h22, ack);
    i2c_master_model_inst.stop_cond();
    rc(`OFS_STATUS, 16'h0840, 16'h0840);
    chk({15'h0, irq}, 16'h0001);
    rc(`OFS_DATA, 16'hffff, 16'h0011);
    apb(1'b1, `OFS_STATUS, 16'h0000);
    rc(`OFS_STATUS, 16'h1f00, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    // check byte: first wrong, then right
    for (int k = 0; k < 2; k++) begin
      i2c_master_model_inst.start_cond();
      i2c_master_model_inst.send_byte(8'hb4, ack);
      i2c_master_model_inst.send_byte(8'h3c, ack);
      apb(1'b0, `OFS_DATA, 16'h0000);
      apb(1'b1, `OFS_CTRL, 16'h000f);
      b = crc8(crc8(8'h00, 8'hb4), 8'h3c) ^ ((k == 0) ? 8'h01 : 8'h00);
      i2c_master_model_inst.send_byte(b, ack);
      i2c_master_model_inst.stop_cond();
      chk({15'h0, ack}, (k == 0) ? 16'h0001 : 16'h0000);
      rc(`OFS_STATUS, 16'h1000, (k == 0) ? 16'h1000 : 16'h0000);
      apb(1'b0, `OFS_DATA, 16'h0000);
      if (k == 0) begin
        apb(1'b1, `OFS_CTRL, 16'h0006);
        rc(`OFS_STATUS, 16'h1000, 16'h0000);
        apb(1'b1, `OFS_CTRL, 16'h0007);
      end
    end
    // arbitration lost in the ack slot drops the byte
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'hb4, ack);
    fork
      i2c_master_model_inst.send_byte(8'h5e, ack);
      begin
        repeat (8) @(posedge scl_w);
        repeat (4) @(posedge pclk);
        arb_lost_in <= 1'b1;
        @(posedge pclk);
        arb_lost_in <= 1'b0;
      end
    join
    i2c_master_model_inst.stop_cond();
    rc(`OFS_STATUS, 16'h0240, 16'h0200);
    chk({15'h0, irq}, 16'h0000);
    apb(1'b1, `OFS_STATUS, 16'h0000);
    // stretching on: an unread byte holds scl low until software reads it
    apb(1'b1, `OFS_CTRL, 16'h0003);
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'hb4, ack);
    i2c_master_model_inst.send_byte(8'h21, ack);
    fork
      i2c_master_model_inst.send_byte(8'h42, ack);
      begin
        repeat (8) @(posedge scl_w);
        repeat (20) @(posedge pclk);
        rc(`OFS_STATUS, 16'h0044, 16'h0044);
        rc(`OFS_DATA, 16'hffff, 16'h0021);
      end
    join
    rc(`OFS_DATA, 16'hffff, 16'h0042);
    i2c_master_model_inst.stop_cond();
    apb(1'b1, `OFS_CTRL, 16'h0007);
    // transmit: overwritten pending byte, then a timely second byte
    apb(1'b1, `OFS_DATA, 16'h0011);
    apb(1'b1, `OFS_DATA, 16'hff5a);
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'hb5, ack);
    rc(`OFS_STATUS, 16'h0080, 16'h0080);
    apb(1'b1, `OFS_DATA, 16'h0096);
    i2c_master_model_inst.recv_byte(1'b0, b);
    chk({8'h00, b}, 16'h005a);
    i2c_master_model_inst.recv_byte(1'b1, b);
    chk({8'h00, b}, 16'h0096);
    i2c_master_model_inst.stop_cond();
    chk({8'h00, stuck}, 16'h0000);
    end_of_test();
  end
endmodule // i2c_data_status_regs_bench
`default_nettype wire
